// [design/rphe_pkg.sv]
// root port hot-plug event logic: shared constants
// assumes a 32-bit apb register bus with one word per register
package rphe_pkg;

    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [7:0] RPHE_ADDR_SLOT_CTRL = 8'h00;
    localparam logic [7:0] RPHE_ADDR_SLOT_STAT = 8'h04;
    localparam logic [7:0] RPHE_ADDR_PORT_CFG = 8'h08;
    localparam logic [7:0] RPHE_ADDR_SMI_SCI = 8'h0C;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    // slot_control_reg
    localparam int RPHE_CTL_PRES_IE = 3;
    localparam int RPHE_CTL_HP_IE = 5;
    localparam int RPHE_CTL_LINK_IE = 12;
    // slot_status_reg
    localparam int RPHE_STS_PRES_CHG = 3;
    localparam int RPHE_STS_PRES_STATE = 6;
    localparam int RPHE_STS_LINK_CHG = 8;
    localparam int RPHE_STS_LINK_STATE = 13;
    // misc_port_config
    localparam int RPHE_CFG_SCI_EN = 0;
    localparam int RPHE_CFG_SMI_EN = 1;
    // smi_sci_status_reg
    localparam int RPHE_SS_SCI = 0;
    localparam int RPHE_SS_PRES_SMI = 1;
    localparam int RPHE_SS_LINK_SMI = 2;

    // ----------------------------------------
    // sticky flag vector layout
    // ----------------------------------------
    localparam int RPHE_NFLAG = 5;
    localparam int RPHE_F_PRES_CHG = 0;
    localparam int RPHE_F_LINK_CHG = 1;
    localparam int RPHE_F_SCI = 2;
    localparam int RPHE_F_PRES_SMI = 3;
    localparam int RPHE_F_LINK_SMI = 4;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [RPHE_NFLAG-1:0] RPHE_FLAG_RST = 5'h00;
    localparam logic [31:0] RPHE_WORD_ZERO = 32'h00000000;
    localparam logic [2:0] RPHE_SYNC_RST = 3'h0;

endpackage : rphe_pkg

// [design/rphe_evt_if.sv]
// root port hot-plug event logic: carrier between sensor and core
// assumes both ends run on the same port clock
`timescale 1ns/1ps
`default_nettype none
interface rphe_evt_if;
    logic presence_state;
    logic presence_change;
    logic link_active;
    logic link_change;

    // sensor drives, core consumes
    modport src (output presence_state, output presence_change,
                 output link_active, output link_change);
    modport dst (input presence_state, input presence_change,
                 input link_active, input link_change);
endinterface : rphe_evt_if
`default_nettype wire

// [design/rphe_event_sense.sv]
// root port hot-plug event logic: presence and link-active sensing
// assumes presence comes from an async pin, link-active from same-clock logic
`timescale 1ns/1ps
`default_nettype none
module rphe_event_sense
    import rphe_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic presence_pin,
    input wire logic link_active_in,
    rphe_evt_if.src evt
);

    logic [2:0] sync;
    logic pres_stable;
    logic link_prev;
    logic pres_agree;

    // ----------------------------------------
    // presence filter
    // ----------------------------------------
    // second and third stages must agree; first stage feeds only the second
    assign pres_agree = (sync[1] == sync[2]);

    // three-stage capture, stable value follows agreement
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sync <= RPHE_SYNC_RST;
            pres_stable <= 1'b0;
            link_prev <= 1'b0;
            evt.presence_state <= 1'b0;
            evt.presence_change <= 1'b0;
            evt.link_active <= 1'b0;
            evt.link_change <= 1'b0;
        end else if (clk_en) begin
            sync <= {sync[1:0], presence_pin};
            if (pres_agree) begin
                pres_stable <= sync[2];
            end
            link_prev <= link_active_in;
            evt.presence_state <= pres_stable;
            // one pulse per insertion or removal
            evt.presence_change <= pres_agree && (sync[2] != pres_stable);
            evt.link_active <= link_prev;
            // link layer is on this clock, no filter needed
            evt.link_change <= (link_active_in != link_prev);
        end
    end

endmodule : rphe_event_sense
`default_nettype wire

// [design/rphe_hotplug.sv]
// root port hot-plug event logic: apb registers, sticky status, outputs
// assumes an apb master on clk_sys and a slot presence pin from the phy
//
// Behaviour
// - insertion sets presence state and changed
// - port interrupt needs both enables set
// - removal clears state, sets changed flag
// - link-active change is also hot-plug event
// - sci enable lets enabled events set sci
// - smi enable lets events set smi flags
// - any smi flag drives smi output
// - smi flags ignore interrupt and sci enables
`timescale 1ns/1ps
`default_nettype none
module rphe_hotplug
    import rphe_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // slot side
    input wire logic presence_pin,
    input wire logic link_active_in,
    // platform side
    output logic port_irq,
    output logic sci,
    output logic system_management_interrupt
);

    rphe_evt_if evt();

    // ----------------------------------------
    // event sensing
    // ----------------------------------------
    rphe_event_sense u_sense (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .presence_pin(presence_pin),
        .link_active_in(link_active_in),
        .evt(evt)
    );

    // ----------------------------------------
    // control state
    // ----------------------------------------
    logic presence_change_irq_enable;
    logic hotplug_irq_enable;
    logic link_change_irq_enable;
    logic hotplug_sci_enable;
    logic hotplug_smi_enable;
    logic [RPHE_NFLAG-1:0] flags;
    logic [RPHE_NFLAG-1:0] next_flags;
    logic [RPHE_NFLAG-1:0] flag_set;
    logic [RPHE_NFLAG-1:0] flag_clr;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic setup_ph;
    logic wr_done;
    logic hit_ctl;
    logic hit_sts;
    logic hit_cfg;
    logic hit_ss;
    logic hit_any;
    logic [31:0] rd_word;
    logic [31:0] ctl_word;
    logic [31:0] sts_word;
    logic [31:0] cfg_word;
    logic [31:0] ss_word;

    // setup phase samples data; the access phase then lasts one cycle
    assign setup_ph = psel && !penable;
    assign wr_done = psel && penable && pready && pwrite;
    assign hit_ctl = (paddr == RPHE_ADDR_SLOT_CTRL);
    assign hit_sts = (paddr == RPHE_ADDR_SLOT_STAT);
    assign hit_cfg = (paddr == RPHE_ADDR_PORT_CFG);
    assign hit_ss = (paddr == RPHE_ADDR_SMI_SCI);
    assign hit_any = hit_ctl || hit_sts || hit_cfg || hit_ss;

    // ----------------------------------------
    // read words
    // ----------------------------------------
    // unlisted bits read as zero
    always_comb begin
        ctl_word = RPHE_WORD_ZERO;
        sts_word = RPHE_WORD_ZERO;
        cfg_word = RPHE_WORD_ZERO;
        ss_word = RPHE_WORD_ZERO;
        ctl_word[RPHE_CTL_PRES_IE] = presence_change_irq_enable;
        ctl_word[RPHE_CTL_HP_IE] = hotplug_irq_enable;
        ctl_word[RPHE_CTL_LINK_IE] = link_change_irq_enable;
        sts_word[RPHE_STS_PRES_CHG] = flags[RPHE_F_PRES_CHG];
        sts_word[RPHE_STS_PRES_STATE] = evt.presence_state;
        sts_word[RPHE_STS_LINK_CHG] = flags[RPHE_F_LINK_CHG];
        sts_word[RPHE_STS_LINK_STATE] = evt.link_active;
        cfg_word[RPHE_CFG_SCI_EN] = hotplug_sci_enable;
        cfg_word[RPHE_CFG_SMI_EN] = hotplug_smi_enable;
        ss_word[RPHE_SS_SCI] = flags[RPHE_F_SCI];
        ss_word[RPHE_SS_PRES_SMI] = flags[RPHE_F_PRES_SMI];
        ss_word[RPHE_SS_LINK_SMI] = flags[RPHE_F_LINK_SMI];
    end

    // read mux, unmapped reads zero
    assign rd_word = hit_ctl ? ctl_word :
                     hit_sts ? sts_word :
                     hit_cfg ? cfg_word :
                     hit_ss ? ss_word : RPHE_WORD_ZERO;

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    // answer registered so every bus output is a flop
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RPHE_WORD_ZERO;
        end else if (clk_en) begin
            pready <= setup_ph;
            pslverr <= setup_ph && !hit_any;
            if (setup_ph && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end

    // ----------------------------------------
    // enable registers
    // ----------------------------------------
    // control and config bits are plain read/write
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            presence_change_irq_enable <= 1'b0;
            hotplug_irq_enable <= 1'b0;
            link_change_irq_enable <= 1'b0;
            hotplug_sci_enable <= 1'b0;
            hotplug_smi_enable <= 1'b0;
        end else if (clk_en && wr_done) begin
            if (hit_ctl) begin
                presence_change_irq_enable <= pwdata[RPHE_CTL_PRES_IE];
                hotplug_irq_enable <= pwdata[RPHE_CTL_HP_IE];
                link_change_irq_enable <= pwdata[RPHE_CTL_LINK_IE];
            end
            if (hit_cfg) begin
                hotplug_sci_enable <= pwdata[RPHE_CFG_SCI_EN];
                hotplug_smi_enable <= pwdata[RPHE_CFG_SMI_EN];
            end
        end
    end

    // ----------------------------------------
    // flag set terms
    // ----------------------------------------
    logic pres_enabled;
    logic link_enabled;

    // an event counts as enabled when its slot interrupt enable is on
    assign pres_enabled = evt.presence_change && presence_change_irq_enable;
    assign link_enabled = evt.link_change && link_change_irq_enable;

    assign flag_set[RPHE_F_PRES_CHG] = evt.presence_change;
    assign flag_set[RPHE_F_LINK_CHG] = evt.link_change;
    assign flag_set[RPHE_F_SCI] = hotplug_sci_enable && (pres_enabled || link_enabled);
    // no interrupt or sci enable here
    assign flag_set[RPHE_F_PRES_SMI] = hotplug_smi_enable && evt.presence_change;
    assign flag_set[RPHE_F_LINK_SMI] = hotplug_smi_enable && evt.link_change;

    // ----------------------------------------
    // flag clear terms (write one to clear)
    // ----------------------------------------
    assign flag_clr[RPHE_F_PRES_CHG] = wr_done && hit_sts && pwdata[RPHE_STS_PRES_CHG];
    assign flag_clr[RPHE_F_LINK_CHG] = wr_done && hit_sts && pwdata[RPHE_STS_LINK_CHG];
    assign flag_clr[RPHE_F_SCI] = wr_done && hit_ss && pwdata[RPHE_SS_SCI];
    assign flag_clr[RPHE_F_PRES_SMI] = wr_done && hit_ss && pwdata[RPHE_SS_PRES_SMI];
    assign flag_clr[RPHE_F_LINK_SMI] = wr_done && hit_ss && pwdata[RPHE_SS_LINK_SMI];

    // ----------------------------------------
    // sticky flags
    // ----------------------------------------
    // a set in the clearing cycle wins so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < RPHE_NFLAG; gi++) begin : g_flag
            assign next_flags[gi] = (flags[gi] && !flag_clr[gi]) || flag_set[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flags <= RPHE_FLAG_RST;
        end else if (clk_en) begin
            flags <= next_flags;
        end
    end

    // ----------------------------------------
    // platform outputs
    // ----------------------------------------
    logic next_irq;
    logic next_sci;
    logic next_smi;

    // both enables gate the port interrupt
    assign next_irq = hotplug_irq_enable
        && ((next_flags[RPHE_F_PRES_CHG] && presence_change_irq_enable)
        || (next_flags[RPHE_F_LINK_CHG] && link_change_irq_enable));
    assign next_sci = next_flags[RPHE_F_SCI] && hotplug_sci_enable;
    assign next_smi = next_flags[RPHE_F_PRES_SMI] || next_flags[RPHE_F_LINK_SMI];

    // outputs stay levels until the flags are cleared or, for irq and sci, an enable gating them goes off
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            port_irq <= 1'b0;
            sci <= 1'b0;
            system_management_interrupt <= 1'b0;
        end else if (clk_en) begin
            port_irq <= next_irq;
            sci <= next_sci;
            system_management_interrupt <= next_smi;
        end
    end

endmodule : rphe_hotplug
`default_nettype wire

// [test/rphe_hotplug_sva.sv]
// hot-plug event checker: apb answer timing and causes of output edges
// assumes binding onto rphe_hotplug; one clock domain
`timescale 1ns/1ps
`default_nettype none
module rphe_hotplug_sva (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic presence_pin,
    input wire logic link_active_in,
    input wire logic port_irq,
    input wire logic sci,
    input wire logic system_management_interrupt
);
    logic [3:0] slot_age;
    logic [3:0] wr_age;
    logic [1:0] slot_q;
    wire logic bad = (paddr[1:0] != 2'h0) || (paddr > 8'h0C);
    wire logic slot_chg = slot_q != {presence_pin, link_active_in};
    wire logic wr_done = psel && penable && pready && pwrite;
    // ages saturate at reset so no edge right after release looks caused
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            slot_age <= 4'hF;
            wr_age <= 4'hF;
            slot_q <= 2'h0;
        end else if (clk_en) begin
            // frozen with the design, so an event held off by clk_en still looks recent
            slot_q <= {presence_pin, link_active_in};
            slot_age <= slot_chg ? 4'h0 : slot_age + {3'h0, slot_age != 4'hF};
            wr_age <= wr_done ? 4'h0 : wr_age + {3'h0, wr_age != 4'hF};
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    sequence s_cause;
        slot_age <= 4'h8 || wr_age <= 4'h3;
    endsequence
    property p_ready; s_setup |=> pready; endproperty
    property p_pulse; pready && clk_en |=> !pready; endproperty
    property p_err; s_setup |=> pslverr == $past(bad); endproperty
    property p_hold; !(psel && !pwrite) |=> $stable(prdata); endproperty
    property p_irq_rise; $rose(port_irq) |-> s_cause; endproperty
    property p_sci_rise; $rose(sci) |-> s_cause; endproperty
    property p_smi_rise; $rose(system_management_interrupt) |-> slot_age <= 4'h8; endproperty
    property p_fall;
        $fell(port_irq) || $fell(sci) || $fell(system_management_interrupt) |-> wr_age <= 4'h3;
    endproperty
    property p_freeze;
        !clk_en |=> $stable({port_irq, sci, system_management_interrupt})
            && $stable({pready, pslverr, prdata});
    endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    a_err: assert property (p_err) else $error("error flag wrong for address");
    a_hold: assert property (p_hold) else $error("read data moved without read");
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose uncaused");
    a_sci_rise: assert property (p_sci_rise) else $error("sci rose uncaused");
    a_smi_rise: assert property (p_smi_rise) else $error("smi rose uncaused");
    a_fall: assert property (p_fall) else $error("output fell without write");
    a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule : rphe_hotplug_sva
bind rphe_hotplug rphe_hotplug_sva u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .presence_pin(presence_pin),
    .link_active_in(link_active_in), .port_irq(port_irq), .sci(sci),
    .system_management_interrupt(system_management_interrupt));
`default_nettype wire

// [test/rphe_slot_model.sv]
// slot partner: a module that is plugged in, powered, and trains its link
// assumes plug and train commands from the bench on the port clock
`timescale 1ns/1ps
`default_nettype none
module rphe_slot_model (
    input wire logic clk_sys,
    input wire logic plugged,
    input wire logic train,
    output logic presence_pin,
    output logic link_active_in
);
    initial begin
        presence_pin = 1'b0;
        link_active_in = 1'b0;
    end
    // presence lands off the edge: the pin is asynchronous to the port
    always @(plugged) presence_pin <= #7 plugged;
    // link only trains while a powered module sits in the slot
    always @(posedge clk_sys) link_active_in <= presence_pin && train;
endmodule : rphe_slot_model
`default_nettype wire

// [test/root_port_hotplug_events_test.sv]
// hot-plug event testbench: registers, insertion, link and removal
// assumes rphe_hotplug with its apb slave and the slot partner model
`timescale 1ns/1ps
`default_nettype none
module root_port_hotplug_events_test
    import rphe_pkg::*;
;
    localparam logic [7:0] CT = RPHE_ADDR_SLOT_CTRL;
    localparam logic [7:0] ST = RPHE_ADDR_SLOT_STAT;
    localparam logic [7:0] CF = RPHE_ADDR_PORT_CFG;
    localparam logic [7:0] SS = RPHE_ADDR_SMI_SCI;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, port_irq, sci, smi, err, presence_pin, link_active_in;
    logic plugged = 1'b0;
    logic train = 1'b0;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    rphe_hotplug DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .presence_pin(presence_pin),
        .link_active_in(link_active_in), .port_irq(port_irq), .sci(sci),
        .system_management_interrupt(smi));
    rphe_slot_model u_slot (.clk_sys(clk_sys), .plugged(plugged), .train(train),
        .presence_pin(presence_pin), .link_active_in(link_active_in));
    always #12.5 clk_sys = ~clk_sys;
    function automatic logic [31:0] b(input int n);
        return 32'h00000001 << n;
    endfunction : b
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // a full scenario needs well under 1000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp);
        check({31'h0, err}, {31'h0, e});
    endtask : rd_chk
    // outputs are registered: let them settle past the last write
    task automatic outs(input logic [2:0] exp);
        repeat (2) @(posedge clk_sys);
        check({29'h0, port_irq, sci, smi}, {29'h0, exp});
    endtask : outs
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // reset values, plus one unmapped word that must be refused
        for (int i = 0; i < 5; i++) rd_chk(8'(i * 4), 32'h00000000, i == 4);
        wr(8'h10, 32'hFFFFFFFF);
        check({31'h0, err}, 32'h00000001);
        wr(CT, b(RPHE_CTL_PRES_IE) | b(RPHE_CTL_HP_IE) | b(RPHE_CTL_LINK_IE));
        wr(CF, b(RPHE_CFG_SCI_EN) | b(RPHE_CFG_SMI_EN));
        rd_chk(CT, 32'h00001028, 1'b0);
        rd_chk(CF, b(RPHE_CFG_SCI_EN) | b(RPHE_CFG_SMI_EN), 1'b0);
        outs(3'b000);
        // insertion with every enable on
        plugged <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rd_chk(ST, b(RPHE_STS_PRES_CHG) | b(RPHE_STS_PRES_STATE), 1'b0);
        rd_chk(SS, b(RPHE_SS_SCI) | b(RPHE_SS_PRES_SMI), 1'b0);
        outs(3'b111);
        wr(ST, 32'hFFFFFFFF);
        wr(SS, 32'hFFFFFFFF);
        rd_chk(ST, b(RPHE_STS_PRES_STATE), 1'b0);
        rd_chk(SS, 32'h00000000, 1'b0);
        outs(3'b000);
        // link trains: a second kind of hot-plug event
        train <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rd_chk(ST, 32'h00002140, 1'b0);
        rd_chk(SS, b(RPHE_SS_SCI) | b(RPHE_SS_LINK_SMI), 1'b0);
        outs(3'b111);
        wr(ST, 32'hFFFFFFFF);
        wr(SS, 32'hFFFFFFFF);
        // removal with hot-plug irq and sci off; link drops with it
        wr(CT, b(RPHE_CTL_PRES_IE));
        wr(CF, b(RPHE_CFG_SMI_EN));
        plugged <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rd_chk(ST, b(RPHE_STS_PRES_CHG) | b(RPHE_STS_LINK_CHG), 1'b0);
        rd_chk(SS, b(RPHE_SS_PRES_SMI) | b(RPHE_SS_LINK_SMI), 1'b0);
        outs(3'b001);
        wr(CT, b(RPHE_CTL_PRES_IE) | b(RPHE_CTL_HP_IE));
        outs(3'b101);
        wr(SS, 32'hFFFFFFFF);
        outs(3'b100);
        // smi enable off: a new insertion leaves smi status alone
        wr(ST, 32'hFFFFFFFF);
        wr(CF, 32'h00000000);
        plugged <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rd_chk(SS, 32'h00000000, 1'b0);
        outs(3'b100);
        // clock enable low: a removal waits until the block runs again
        wr(ST, 32'hFFFFFFFF);
        clk_en <= 1'b0;
        plugged <= 1'b0;
        repeat (10) @(posedge clk_sys);
        check({29'h0, port_irq, sci, smi}, 32'h00000000);
        clk_en <= 1'b1;
        repeat (10) @(posedge clk_sys);
        outs(3'b100);
        rd_chk(ST, b(RPHE_STS_PRES_CHG) | b(RPHE_STS_LINK_CHG), 1'b0);
        print_verdict();
    end
endmodule : root_port_hotplug_events_test
`default_nettype wire
